// ### shared/monitor_entry_params.svh
`ifndef MONITOR_ENTRY_PARAMS_SVH
`define MONITOR_ENTRY_PARAMS_SVH
`define MON_SECURITY_BYTES 4'h8
`define MON_BREAK_BITS 4'hA
`define MON_FRAME_BITS 4'hA
`define MON_BAUD 9600
`define MON_CLK_HZ 100000000
`define MON_BIT_CYCLES (`MON_CLK_HZ / `MON_BAUD)
`define MON_ERASED_BYTE 8'hFF
`endif

// ### shared/monitor_entry_pkg.sv
package monitor_entry_pkg;
   typedef enum logic [1:0] {bus_div2, bus_div4} bus_div_type;
   typedef struct packed {
      logic vector_erased;
      logic irq_high_voltage;
      logic divisor_high;
   } entry_cond_type;
   typedef struct packed {
      logic in_monitor;
      logic entered_by_voltage;
      logic entered_by_blank;
      logic osc_bypass;
      bus_div_type bus_div;
      logic watchdog_disable;
      logic extra_reset;
      logic ready_for_command;
   } mon_status_type;
endpackage

// ### hdl/monitor_mode_entry.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_entry_params.svh"
module monitor_mode_entry #(
   parameter int unsigned BIT_CYCLES = `MON_BIT_CYCLES
) (
   input wire logic ref_clk, // system clock
   input wire logic arst_n, // async reset, active low
   input wire logic clk_en, // freezes all state while low
   input wire logic reset_pin_n, // external reset pin level
   input wire logic reset_pin_high_voltage, // test voltage seen on reset pin
   input wire logic power_on_reset, // power-on reset event
   input wire logic [7:0] reset_vector_hi, // vector byte at top-1
   input wire logic [7:0] reset_vector_lo, // vector byte at top
   input wire logic external_interrupt_pin, // test voltage detect on irq pin
   input wire logic divisor_select_pin, // divisor pin level
   input wire logic serial_rx, // serial line from host
   output logic serial_tx, // serial line to host
   output logic serial_tx_oe, // high while driving tx
   output logic extra_reset_req, // one-cycle request for extra reset
   output monitor_entry_pkg::mon_status_type status // latched mode state
);
   import monitor_entry_pkg::*;
   // ************************************************
   // decode helpers
   // ************************************************
   function automatic logic byte_erased(input logic [7:0] value);
      return value == `MON_ERASED_BYTE;
   endfunction
   // divide-by-two bus and oscillator bypass both need high voltage with the divisor pin low
   function automatic logic fast_clock(input entry_cond_type c);
      return c.irq_high_voltage && !c.divisor_high;
   endfunction
   // ************************************************
   // pin synchronisers
   // ************************************************
   localparam int unsigned PIN_COUNT = 5;
   // slot order: reset pin, irq voltage, reset-pin voltage, divisor pin, serial rx
   // only the serial line rests high, so no false start bit follows reset
   localparam logic [4:0] PIN_IDLE = 5'h01;
   wire logic [4:0] pins_in = {reset_pin_n, external_interrupt_pin, reset_pin_high_voltage,
                               divisor_select_pin, serial_rx};
   wire logic [4:0] pins_f;
   for (genvar gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      logic [2:0] chain_q;
      logic level_q;
      always_ff @(posedge ref_clk or negedge arst_n) begin
         if (!arst_n) begin
            chain_q <= {3{PIN_IDLE[gi]}};
            level_q <= PIN_IDLE[gi];
         end else if (clk_en) begin
            chain_q <= {chain_q[1:0], pins_in[gi]};
            // a change counts once the second and third stages agree, so a glitch is dropped
            if (chain_q[1] == chain_q[2]) begin
               level_q <= chain_q[2];
            end
         end
      end
      assign pins_f[gi] = level_q;
   end
   wire logic rst_f = pins_f[4];
   wire logic hv_f = pins_f[3];
   wire logic rhv_f = pins_f[2];
   wire logic div_f = pins_f[1];
   wire logic rx_f = pins_f[0];
   // ************************************************
   // entry decision
   // ************************************************
   typedef enum logic [1:0] {ph_idle, ph_secure, ph_break, ph_ready} phase_type;
   phase_type ph_q;
   logic rst_prev_q;
   logic por_seen_q;
   logic extra_done_q;
   entry_cond_type cond_q;
   mon_status_type st_q;
   wire logic vec_erased = byte_erased(reset_vector_hi) && byte_erased(reset_vector_lo);
   wire logic div_high_eff = hv_f && div_f;
   wire entry_cond_type cond_d = {vec_erased, hv_f, div_high_eff};
   wire logic reset_rise = rst_f && !rst_prev_q;
   // the decision uses what was sampled while reset was low, never the live pins
   wire logic enter_voltage = cond_q.irq_high_voltage;
   wire logic enter_blank = cond_q.vector_erased && !cond_q.irq_high_voltage;
   wire logic enter_any = por_seen_q && (enter_voltage || enter_blank);
   wire logic latch_now = reset_rise && !st_q.in_monitor && enter_any;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_prev_q <= 1'h0;
         por_seen_q <= 1'h0;
         cond_q <= '0;
      end else if (clk_en) begin
         rst_prev_q <= rst_f;
         if (power_on_reset) begin
            por_seen_q <= 1'h1;
         end
         // frozen once the mode is latched, so a later reset pulse cannot disturb it
         if (!rst_f && !st_q.in_monitor) begin
            cond_q <= cond_d;
         end
      end
   end
   // ************************************************
   // latched mode and watchdog hold-off
   // ************************************************
   wire bus_div_type div_d = fast_clock(cond_q) ? bus_div2 : bus_div4;
   wire logic hold_wd = st_q.entered_by_blank ||
                        (st_q.entered_by_voltage && (hv_f || rhv_f));
   // the hold-off starts at the latch edge itself, not one cycle after it
   wire logic wd_d = latch_now ? (!cond_q.irq_high_voltage || hv_f || rhv_f) : hold_wd;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
         extra_done_q <= 1'h0;
      end else if (clk_en) begin
         if (latch_now) begin
            st_q.in_monitor <= 1'h1;
            st_q.entered_by_voltage <= enter_voltage;
            st_q.entered_by_blank <= enter_blank;
            st_q.osc_bypass <= fast_clock(cond_q);
            st_q.bus_div <= div_d;
            st_q.extra_reset <= enter_blank && !extra_done_q;
         end else begin
            st_q.extra_reset <= 1'h0;
         end
         if (st_q.extra_reset) begin
            extra_done_q <= 1'h1;
         end
         st_q.watchdog_disable <= wd_d;
         st_q.ready_for_command <= (ph_q == ph_ready);
      end
   end
   assign extra_reset_req = st_q.extra_reset;
   assign status = st_q;
   // ************************************************
   // serial link: security bytes then break
   // ************************************************
   logic [15:0] baud_q;
   logic [3:0] bit_q;
   logic [3:0] bytes_q;
   logic rx_busy_q;
   logic tx_q;
   // the bit timer is 16 bits wide: a bit time above 65536 clocks would wrap
   wire logic bit_tick = (baud_q == 16'(BIT_CYCLES - 1));
   wire logic half_tick = (baud_q == 16'(BIT_CYCLES / 2));
   wire logic start_seen = (ph_q == ph_secure) && !rx_busy_q && !rx_f;
   wire logic frame_end = (ph_q == ph_secure) && rx_busy_q && half_tick &&
                          (bit_q == `MON_FRAME_BITS - 4'h1);
   wire logic last_byte = (bytes_q == `MON_SECURITY_BYTES - 4'h1);
   wire logic break_start = frame_end && last_byte;
   wire logic break_end = (ph_q == ph_break) && bit_tick &&
                          (bit_q == `MON_BREAK_BITS - 4'h1);
   // the timer restarts at each start bit and at the break, so the first break bit is whole
   wire logic baud_clr = bit_tick || break_start || ((ph_q == ph_secure) && !rx_busy_q);
   wire logic [15:0] baud_d = baud_clr ? 16'h0000 : baud_q + 16'h0001;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_q <= ph_idle;
         baud_q <= 16'h0000;
         bit_q <= 4'h0;
         bytes_q <= 4'h0;
         rx_busy_q <= 1'h0;
         tx_q <= 1'h1;
      end else if (clk_en) begin
         baud_q <= baud_d;
         case (ph_q)
            ph_idle: begin
               if (st_q.in_monitor && rst_f) begin
                  ph_q <= ph_secure;
               end
            end
            ph_secure: begin
               if (start_seen) begin
                  rx_busy_q <= 1'h1;
                  bit_q <= 4'h0;
               end else if (rx_busy_q && half_tick) begin
                  bit_q <= bit_q + 4'h1;
                  // contents are only counted; checking them is left to the firmware
                  if (frame_end) begin
                     rx_busy_q <= 1'h0;
                     bytes_q <= bytes_q + 4'h1;
                  end
                  if (break_start) begin
                     ph_q <= ph_break;
                     bit_q <= 4'h0;
                     tx_q <= 1'h0;
                  end
               end
            end
            ph_break: begin
               if (bit_tick) begin // ten zero bits
                  bit_q <= bit_q + 4'h1;
               end
               if (break_end) begin
                  tx_q <= 1'h1;
                  ph_q <= ph_ready;
               end
            end
            ph_ready: begin
               ph_q <= ph_ready;
            end
            default: begin
               ph_q <= ph_idle;
            end
         endcase
      end
   end
   // open-drain style: the line is only pulled low while the break runs
   assign serial_tx = tx_q;
   assign serial_tx_oe = (ph_q == ph_break);
endmodule
`default_nettype wire

// ### bench/monitor_mode_entry_chk.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_mode_entry_chk import monitor_entry_pkg::*; #(
   parameter int unsigned BIT_CYCLES = 16
) (
   input wire logic ref_clk, // clock
   input wire logic arst_n, // reset
   input wire logic external_interrupt_pin, // irq voltage
   input wire logic serial_tx, // tx line
   input wire logic serial_tx_oe, // tx drive
   input wire logic extra_reset_req, // extra reset
   input wire monitor_entry_pkg::mon_status_type status // mode
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   logic [15:0] brk_q;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) brk_q <= 16'h0000;
      else brk_q <= serial_tx_oe ? brk_q + 16'h0001 : 16'h0000;
   end
   bypass_only_a: assert property (status.osc_bypass |-> status.entered_by_voltage &&
      status.bus_div == bus_div2) else $error("bypass without voltage entry");
   blank_div_a: assert property (status.entered_by_blank |-> status.bus_div == bus_div4)
      else $error("blank entry not div4");
   blank_wd_a: assert property (status.entered_by_blank |-> status.watchdog_disable)
      else $error("watchdog on after blank entry");
   latch_hold_a: assert property (status.in_monitor |=> status.in_monitor &&
      $stable(status.bus_div) && $stable(status.osc_bypass)) else $error("latch moved");
   break_low_a: assert property (serial_tx_oe |-> !serial_tx) else $error("break not low");
   break_len_a: assert property ($fell(serial_tx_oe) |-> brk_q == 10 * BIT_CYCLES)
      else $error("break length wrong");
   extra_one_a: assert property (extra_reset_req |-> status.entered_by_blank
      ##1 !extra_reset_req[*8]) else $error("extra reset wrong");
   wd_volt_a: assert property (status.entered_by_voltage && external_interrupt_pin [*8]
      |-> status.watchdog_disable) else $error("watchdog on under voltage");
   ready_a: assert property ($fell(serial_tx_oe) |-> ##[0:2] status.ready_for_command)
      else $error("no ready after break");
   cover property (status.entered_by_blank);
   cover property (status.osc_bypass);
   cover property ($fell(serial_tx_oe));
endmodule
bind monitor_mode_entry monitor_mode_entry_chk #(.BIT_CYCLES(BIT_CYCLES)) chk_i (
   .ref_clk(ref_clk), .arst_n(arst_n), .external_interrupt_pin(external_interrupt_pin),
   .serial_tx(serial_tx), .serial_tx_oe(serial_tx_oe), .extra_reset_req(extra_reset_req),
   .status(status));
`default_nettype wire

// ### bench/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model #(
   parameter int unsigned BIT_CYCLES = 16
) (
   input wire logic ref_clk, // clock
   input wire logic go, // start security bytes
   output logic serial_rx, // line to device, idle high
   output logic done // last stop bit begun
);
   initial begin
      logic [9:0] fr;
      serial_rx = 1'b1;
      done = 1'b0;
      @(posedge go);
      for (int i = 0; i < 8; i++) begin
         fr = {1'b1, 8'h5A ^ 8'(i), 1'b0};
         for (int b = 0; b < 10; b++) begin
            @(posedge ref_clk);
            serial_rx <= fr[b];
            if (i == 7 && b == 9) begin
               done <= 1'b1; // last stop bit under way
            end
            repeat (BIT_CYCLES - 1) @(posedge ref_clk);
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/monitor_mode_entry_tb.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_mode_entry_tb;
   import monitor_entry_pkg::*;
   localparam int unsigned BC = 16;
   logic ref_clk = 1'b0, arst_n = 1'b0, rst_n = 1'b0, rst_hv = 1'b0, por = 1'b0, irq = 1'b0;
   logic div = 1'b0, go = 1'b0, rx, tx, oe, xr, done;
   logic [7:0] vec = 8'hFF;
   mon_status_type st;
   int err_total = 0, checks = 0, xr_n = 0;
   monitor_mode_entry #(.BIT_CYCLES(BC)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(1'b1),
      .reset_pin_n(rst_n), .reset_pin_high_voltage(rst_hv), .power_on_reset(por),
      .reset_vector_hi(vec), .reset_vector_lo(vec), .external_interrupt_pin(irq),
      .divisor_select_pin(div), .serial_rx(rx), .serial_tx(tx), .serial_tx_oe(oe),
      .extra_reset_req(xr), .status(st));
   host_link_model #(.BIT_CYCLES(BC)) host (.ref_clk(ref_clk), .go(go), .serial_rx(rx), .done(done));
   initial forever #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (xr === 1'b1) xr_n++;
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // entry with given vector state, irq voltage and divisor; pins moved after latch
   task automatic entry(input logic e, input logic h, input logic d);
      arst_n = 1'b0;
      rst_n = 1'b0;
      vec = e ? 8'hFF : 8'h3C;
      {irq, div, por} = {h, d, 1'b1};
      step(2);
      arst_n = 1'b1;
      xr_n = 0;
      step(4);
      rst_n = 1'b1;
      step(10);
      {div, vec} = {~d, ~vec};
      step(6);
      chk(8'(st.in_monitor), 8'(e | h));
      if (e | h) begin
         chk(8'(st.bus_div), 8'((h & !d) ? bus_div2 : bus_div4));
         chk(8'(st.osc_bypass), 8'(h & !d));
         chk({st.entered_by_voltage, st.entered_by_blank, st.watchdog_disable},
             {5'h00, h, e & !h, 1'b1});
      end
      chk(8'(xr_n), 8'(e));
   endtask
   task automatic watchdog_hold;
      {irq, rst_hv} = 2'b01;
      step(12);
      chk(8'(st.watchdog_disable), 8'h01);
      rst_hv = 1'b0;
      step(12);
      chk(8'(st.watchdog_disable), 8'h00);
   endtask
   task automatic security_break;
      int n = 0;
      go = 1'b1;
      for (int i = 0; i < 4000 && !oe; i++) step(1);
      chk(8'(done), 8'h01);
      while (oe === 1'b1 && n < 400) begin
         chk(8'(tx), 8'h00);
         n++;
         step(1);
      end
      step(2);
      chk(8'(n), 8'(10 * BC));
      chk(8'(st.ready_for_command), 8'h01);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      step(16);
      entry(1'b1, 1'b0, 1'b1);
      entry(1'b0, 1'b0, 1'b0);
      entry(1'b0, 1'b1, 1'b0);
      entry(1'b0, 1'b1, 1'b1);
      watchdog_hold();
      entry(1'b0, 1'b1, 1'b1);
      security_break();
      tally_and_finish();
   end
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
